// *** rtl/qpot_defs.vh ***
// Shared constants for the quad pot command port
`ifndef QPOT_DEFS_VH
`define QPOT_DEFS_VH

`define QPOT_CLK_PERIOD_NS  8
`define QPOT_NV_WRITE_NS    10000000
`define QPOT_WIDTH          6
`define QPOT_WIPER_MAX      6'h3f
`define QPOT_WIPER_MIN      6'h00
`define QPOT_SLOT_INIT      6'h20
`define QPOT_POWER_UP_SLOT  2'h0
`define QPOT_BYTE_BITS      4'h8
`define QPOT_PAD_ZEROS      2'h0

`define QPOT_OP_READ_WIPER  4'h9
`define QPOT_OP_WRITE_WIPER 4'ha
`define QPOT_OP_READ_SLOT   4'hb
`define QPOT_OP_WRITE_SLOT  4'hc
`define QPOT_OP_LOAD_WIPER  4'hd
`define QPOT_OP_SAVE_WIPER  4'he
`define QPOT_OP_GLOBAL_LOAD 4'h1
`define QPOT_OP_GLOBAL_SAVE 4'h8
`define QPOT_OP_STEP        4'h2

`define QPOT_ACT_NONE       2'h0
`define QPOT_ACT_LOAD       2'h1
`define QPOT_ACT_SAVE       2'h2
`define QPOT_ACT_WSLOT      2'h3

`endif

// *** rtl/qpot_nv_timer.v ***
// Busy timer for the nonvolatile write cycle
`timescale 1ns/1ps
`include "qpot_defs.vh"

module qpot_nv_timer #(
  parameter CYCLES = 1250000,
  parameter CW     = 21
) (
  input  wire clk_in,
  input  wire reset_in,
  input  wire start_in,
  output wire busy_out
);

  reg [CW-1:0] count_q;

  always @(posedge clk_in) begin
    if (reset_in) begin
      count_q <= {CW{1'b0}};
    end else if (start_in) begin
      count_q <= CYCLES[CW-1:0];
    end else if (count_q != {CW{1'b0}}) begin
      count_q <= count_q - {{(CW-1){1'b0}}, 1'b1};
    end
  end

  assign busy_out = (count_q != {CW{1'b0}});

endmodule

// *** rtl/qpot_cmd_port.v ***
// Quad pot 2-wire command interpreter with wiper counters and setting slots
`timescale 1ns/1ps
`include "qpot_defs.vh"

module qpot_cmd_port #(
  parameter [3:0] TYPE_CODE       = 4'h6,
  parameter       NV_WRITE_CYCLES = `QPOT_NV_WRITE_NS / `QPOT_CLK_PERIOD_NS,
  parameter       NV_CW           = 21
) (
  input  wire        clk_in,
  input  wire        reset_in,
  input  wire        scl_in,
  input  wire        sda_in,
  input  wire [3:0]  strap_address_bits_in,
  output wire        sda_out,
  output wire        sda_oe_out,
  output wire [23:0] wiper_position_out,
  output wire        nv_busy_out
);

  localparam [7:0] S_IDLE  = 8'h01;
  localparam [7:0] S_ADDR  = 8'h02;
  localparam [7:0] S_INSTR = 8'h04;
  localparam [7:0] S_WDATA = 8'h08;
  localparam [7:0] S_RDATA = 8'h10;
  localparam [7:0] S_HACK  = 8'h20;
  localparam [7:0] S_STEP  = 8'h40;
  localparam [7:0] S_DONE  = 8'h80;

  reg  [1:0] scl_sync_q;
  reg  [1:0] sda_sync_q;
  reg  [3:0] strap_m_q;
  reg  [3:0] strap_q;
  reg        scl_p_q;
  reg        sda_p_q;
  reg  [7:0] state_q;
  reg  [7:0] next_q;
  reg  [7:0] shift_q;
  reg  [7:0] tx_q;
  reg  [3:0] bit_q;
  reg        ack_q;
  reg        drv_q;
  reg  [3:0] opc_q;
  reg  [1:0] pot_q;
  reg  [1:0] sel_q;
  reg        glob_q;
  reg  [1:0] act_q;
  reg  [5:0] data_q;
  reg        recall_q;
  reg        nv_start_q;
  reg  [5:0] wiper_q [0:3];
  reg  [5:0] slot_q  [0:15];
  reg  [2:0] i;
  wire       nv_busy;
  wire       scl_s;
  wire       sda_s;
  wire       scl_rise;
  wire       scl_fall;
  wire       start_cond;
  wire       stop_cond;
  wire [5:0] wiper_sel;
  wire [5:0] slot_sel;
  wire [3:0] opc_in;

  assign scl_s      = scl_sync_q[1];
  assign sda_s      = sda_sync_q[1];
  assign scl_rise   = scl_s & ~scl_p_q;
  assign scl_fall   = ~scl_s & scl_p_q;
  assign start_cond = scl_s & scl_p_q & sda_p_q & ~sda_s;
  assign stop_cond  = scl_s & scl_p_q & ~sda_p_q & sda_s;
  assign opc_in     = shift_q[7:4];
  assign wiper_sel  = wiper_q[shift_q[1:0]];
  assign slot_sel   = slot_q[{shift_q[1:0], shift_q[3:2]}];

  // Pin synchronisers
  always @(posedge clk_in) begin
    if (reset_in) begin
      scl_sync_q <= 2'h3;
      sda_sync_q <= 2'h3;
      strap_m_q  <= 4'h0;
      strap_q    <= 4'h0;
      scl_p_q    <= 1'b1;
      sda_p_q    <= 1'b1;
    end else begin
      scl_sync_q <= {scl_sync_q[0], scl_in};
      sda_sync_q <= {sda_sync_q[0], sda_in};
      strap_m_q  <= strap_address_bits_in;
      strap_q    <= strap_m_q;
      scl_p_q    <= scl_s;
      sda_p_q    <= sda_s;
    end
  end

  qpot_nv_timer #(
    .CYCLES (NV_WRITE_CYCLES),
    .CW     (NV_CW)
  ) u_nv_timer (
    .clk_in   (clk_in),
    .reset_in (reset_in),
    .start_in (nv_start_q),
    .busy_out (nv_busy)
  );

  // Protocol engine and register storage
  always @(posedge clk_in) begin
    nv_start_q <= 1'b0;
    if (reset_in) begin
      state_q  <= S_IDLE;
      next_q   <= S_IDLE;
      shift_q  <= 8'h00;
      tx_q     <= 8'h00;
      bit_q    <= 4'h0;
      ack_q    <= 1'b0;
      drv_q    <= 1'b0;
      opc_q    <= 4'h0;
      pot_q    <= 2'h0;
      sel_q    <= 2'h0;
      glob_q   <= 1'b0;
      act_q    <= `QPOT_ACT_NONE;
      data_q   <= 6'h00;
      recall_q <= 1'b1;
      for (i = 3'h0; i < 3'h4; i = i + 3'h1) begin
        wiper_q[i[1:0]] <= `QPOT_WIPER_MIN;
      end
      for (i = 3'h0; i < 3'h4; i = i + 3'h1) begin
        slot_q[{i[1:0], 2'h0}] <= `QPOT_SLOT_INIT;
        slot_q[{i[1:0], 2'h1}] <= `QPOT_SLOT_INIT;
        slot_q[{i[1:0], 2'h2}] <= `QPOT_SLOT_INIT;
        slot_q[{i[1:0], 2'h3}] <= `QPOT_SLOT_INIT;
      end
    end else if (recall_q) begin
      recall_q <= 1'b0;
      for (i = 3'h0; i < 3'h4; i = i + 3'h1) begin
        wiper_q[i[1:0]] <= slot_q[{i[1:0], `QPOT_POWER_UP_SLOT}];
      end
    end else if (stop_cond) begin
      state_q <= S_IDLE;
      ack_q   <= 1'b0;
      drv_q   <= 1'b0;
      act_q   <= `QPOT_ACT_NONE;
      for (i = 3'h0; i < 3'h4; i = i + 3'h1) begin
        if (glob_q || (i[1:0] == pot_q)) begin
          case (act_q)
            `QPOT_ACT_LOAD: wiper_q[i[1:0]] <= slot_q[{i[1:0], sel_q}];
            `QPOT_ACT_SAVE: slot_q[{i[1:0], sel_q}] <= wiper_q[i[1:0]];
            `QPOT_ACT_WSLOT: slot_q[{i[1:0], sel_q}] <= data_q;
            default: ;
          endcase
        end
      end
      if ((act_q == `QPOT_ACT_SAVE) || (act_q == `QPOT_ACT_WSLOT)) begin
        nv_start_q <= 1'b1;
      end
    end else if (start_cond) begin
      state_q <= S_ADDR;
      bit_q   <= 4'h0;
      ack_q   <= 1'b0;
      drv_q   <= 1'b0;
      act_q   <= `QPOT_ACT_NONE;
    end else begin
      case (state_q)
        S_ADDR, S_INSTR, S_WDATA: begin
          if (scl_rise && !ack_q) begin
            shift_q <= {shift_q[6:0], sda_s};
            bit_q   <= bit_q + 4'h1;
          end else if (scl_fall && ack_q) begin
            ack_q   <= 1'b0;
            drv_q   <= 1'b0;
            bit_q   <= 4'h0;
            state_q <= next_q;
            if (next_q == S_RDATA) begin
              drv_q <= ~tx_q[7];
              tx_q  <= {tx_q[6:0], 1'b0};
              bit_q <= 4'h1;
            end
          end else if (scl_fall && (bit_q == `QPOT_BYTE_BITS)) begin
            ack_q   <= 1'b1;
            drv_q   <= 1'b1;
            state_q <= state_q;
            if (state_q == S_ADDR) begin
              next_q <= S_INSTR;
              if ((opc_in != TYPE_CODE) || (shift_q[3:0] != strap_q) || nv_busy) begin
                ack_q   <= 1'b0;
                drv_q   <= 1'b0;
                state_q <= S_DONE;
              end
            end else if (state_q == S_INSTR) begin
              opc_q  <= opc_in;
              pot_q  <= shift_q[1:0];
              sel_q  <= shift_q[3:2];
              glob_q <= 1'b0;
              next_q <= S_DONE;
              case (opc_in)
                `QPOT_OP_READ_WIPER: begin
                  tx_q   <= {`QPOT_PAD_ZEROS, wiper_sel};
                  next_q <= S_RDATA;
                end
                `QPOT_OP_READ_SLOT: begin
                  tx_q   <= {`QPOT_PAD_ZEROS, slot_sel};
                  next_q <= S_RDATA;
                end
                `QPOT_OP_WRITE_WIPER, `QPOT_OP_WRITE_SLOT: begin
                  next_q <= S_WDATA;
                end
                `QPOT_OP_LOAD_WIPER: begin
                  act_q <= `QPOT_ACT_LOAD;
                end
                `QPOT_OP_SAVE_WIPER: begin
                  act_q <= `QPOT_ACT_SAVE;
                end
                `QPOT_OP_GLOBAL_LOAD: begin
                  act_q  <= `QPOT_ACT_LOAD;
                  glob_q <= 1'b1;
                end
                `QPOT_OP_GLOBAL_SAVE: begin
                  act_q  <= `QPOT_ACT_SAVE;
                  glob_q <= 1'b1;
                end
                `QPOT_OP_STEP: begin
                  next_q <= S_STEP;
                end
                default: begin
                  ack_q   <= 1'b0;
                  drv_q   <= 1'b0;
                  state_q <= S_DONE;
                end
              endcase
            end else begin
              next_q <= S_DONE;
              if (opc_q == `QPOT_OP_WRITE_WIPER) begin
                wiper_q[pot_q] <= shift_q[5:0];
              end else begin
                act_q  <= `QPOT_ACT_WSLOT;
                data_q <= shift_q[5:0];
              end
            end
          end
        end
        S_RDATA: begin
          if (scl_fall) begin
            if (bit_q == `QPOT_BYTE_BITS) begin
              drv_q   <= 1'b0;
              state_q <= S_HACK;
            end else begin
              drv_q <= ~tx_q[7];
              tx_q  <= {tx_q[6:0], 1'b0};
              bit_q <= bit_q + 4'h1;
            end
          end
        end
        S_HACK: begin
          if (scl_fall) begin
            state_q <= S_DONE;
          end
        end
        S_STEP: begin
          if (scl_fall) begin
            if (sda_s && (wiper_q[pot_q] != `QPOT_WIPER_MAX)) begin
              wiper_q[pot_q] <= wiper_q[pot_q] + 6'h01;
            end else if (!sda_s && (wiper_q[pot_q] != `QPOT_WIPER_MIN)) begin
              wiper_q[pot_q] <= wiper_q[pot_q] - 6'h01;
            end
          end
        end
        S_IDLE, S_DONE: begin
          drv_q <= 1'b0;
        end
        default: begin
          state_q <= S_IDLE;
        end
      endcase
    end
  end

  // Open-drain data pin: only ever pulls low
  assign sda_out            = 1'b0;
  assign sda_oe_out         = drv_q;
  assign nv_busy_out        = nv_busy;
  assign wiper_position_out = {wiper_q[3], wiper_q[2], wiper_q[1], wiper_q[0]};

endmodule

// *** verif/qpot_cmd_port_assertions.sv ***
// Pin-level checks for the quad pot command port
`timescale 1ns/1ps
module qpot_chk #(
  parameter NV_WRITE_CYCLES = 400
) (
  input wire        clk_in,
  input wire        reset_in,
  input wire        scl_in,
  input wire        sda_in,
  input wire [3:0]  strap_address_bits_in,
  input wire        sda_out,
  input wire        sda_oe_out,
  input wire [23:0] wiper_position_out,
  input wire        nv_busy_out
);
  int n_q;
  int e_q;
  // Busy length, and cycles since the last SCL fall or SDA rise
  always @(posedge clk_in) begin
    n_q <= nv_busy_out ? n_q + 1 : 0;
    if (reset_in || $fell(scl_in) || $rose(sda_in))
      e_q <= 0;
    else if (e_q < 99)
      e_q <= e_q + 1;
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);
  sequence s_oe_on;
    $rose(sda_oe_out);
  endsequence
  sequence s_nv_end;
    $fell(nv_busy_out);
  endsequence
  a_sda_low_only: assert property (sda_out == 1'b0)
    else $error("sda data driven high");
  a_reset_quiet: assert property (disable iff (1'b0) reset_in |=> !nv_busy_out)
    else $error("busy during reset");
  a_power_up_load: assert property ($fell(reset_in) |-> ##[1:2] wiper_position_out == {4{6'h20}})
    else $error("slot 0 not loaded");
  a_nv_length: assert property (s_nv_end |-> n_q >= NV_WRITE_CYCLES - 1 && n_q <= NV_WRITE_CYCLES)
    else $error("busy length wrong");
  a_nv_after_stop: assert property ($rose(nv_busy_out) |-> scl_in && sda_in)
    else $error("busy not after stop");
  a_busy_freeze: assert property (nv_busy_out && $past(nv_busy_out) |-> $stable(wiper_position_out))
    else $error("wiper moved while busy");
  a_wiper_cause: assert property (!$stable(wiper_position_out) |-> e_q <= 8)
    else $error("wiper moved without bus edge");
  a_oe_scl_low: assert property ($changed(sda_oe_out) |-> !scl_in)
    else $error("sda drive changed with scl high");
  a_oe_release: assert property (s_oe_on |-> ##[1:200] !sda_oe_out)
    else $error("sda never released");
endmodule
bind qpot_cmd_port qpot_chk #(.NV_WRITE_CYCLES(NV_WRITE_CYCLES)) u_qpot_chk (
  .clk_in(clk_in), .reset_in(reset_in), .scl_in(scl_in), .sda_in(sda_in),
  .strap_address_bits_in(strap_address_bits_in), .sda_out(sda_out),
  .sda_oe_out(sda_oe_out), .wiper_position_out(wiper_position_out),
  .nv_busy_out(nv_busy_out));

// *** verif/qpot_bus.sv ***
// Two-wire bus master model for the quad pot command port
`timescale 1ns/1ps
module qpot_bus (
  input  wire  clk_in,
  input  wire  sda_in,
  output logic scl_out,
  output logic sda_out
);
  initial begin
    scl_out = 1'b1;
    sda_out = 1'b1;
  end
  task automatic w(input int n);
    repeat (n) @(negedge clk_in);
  endtask
  // SDA held over the whole high phase and the fall
  task automatic b(input logic d, output logic r);
    w(2);
    sda_out = d;
    w(2);
    scl_out = 1'b1;
    w(4);
    r = sda_in;
    scl_out = 1'b0;
  endtask
  task automatic s;
    w(2);
    sda_out = 1'b1;
    w(2);
    scl_out = 1'b1;
    w(4);
    sda_out = 1'b0;
    w(4);
    scl_out = 1'b0;
  endtask
  task automatic p;
    w(2);
    sda_out = 1'b0;
    w(2);
    scl_out = 1'b1;
    w(4);
    sda_out = 1'b1;
    w(4);
  endtask
  // Byte out MSB first, then the acknowledge bit h
  task automatic x(input logic [7:0] d, input logic h, output logic [7:0] r, output logic a);
    for (int i = 7; i >= 0; i--)
      b(d[i], r[i]);
    b(h, a);
  endtask
endmodule

// *** verif/tb.sv ***
// Self-checking bench for the quad pot command port
`timescale 1ns/1ps
module tb;
  localparam logic [3:0] TC = 4'h6; // Arbitrary type code
  localparam logic [3:0] SA = 4'h9;
  logic       clk_in = 1'b0;
  logic       reset_in = 1'b1;
  logic [3:0] strap = SA;
  logic [7:0] r;
  logic       a;
  wire        scl, hs, oe, sdo, busy;
  wire [23:0] wp;
  int         errors = 0;
  int         comparisons = 0;
  wire        sda = hs & ~oe;
  always #4 clk_in = ~clk_in;
  qpot_cmd_port #(.TYPE_CODE(TC), .NV_WRITE_CYCLES(400)) u_qpot_cmd_port (
    .clk_in(clk_in), .reset_in(reset_in), .scl_in(scl), .sda_in(sda),
    .strap_address_bits_in(strap), .sda_out(sdo), .sda_oe_out(oe),
    .wiper_position_out(wp), .nv_busy_out(busy));
  qpot_bus u_qpot_bus (.clk_in(clk_in), .sda_in(sda), .scl_out(scl), .sda_out(hs));
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    comparisons++;
    if (s !== e) begin
      errors++;
      $display("ERROR %0t: saw %h expected %h", $time, s, e);
    end
  endtask
  task automatic finish_test;
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  function automatic logic [7:0] pot(input int p);
    return {2'b00, wp[6*p+:6]};
  endfunction
  task automatic idle;
    int i;
    for (i = 0; i < 1000 && busy !== 1'b0; i++)
      @(negedge clk_in);
    if (i == 1000) begin
      errors++;
      finish_test();
    end
  endtask
  task automatic nack(input logic [7:0] ad);
    u_qpot_bus.s();
    u_qpot_bus.x(ad, 1'b1, r, a);
    chk(8'(a), 8'h1);
    u_qpot_bus.p();
  endtask
  task automatic op(input logic [7:0] ins, input logic [7:0] d);
    idle();
    u_qpot_bus.s();
    u_qpot_bus.x({TC, SA}, 1'b1, r, a);
    chk(8'(a), 8'h0);
    u_qpot_bus.x(ins, 1'b1, r, a);
    chk(8'(a), 8'h0);
    if (ins[7:4] == 4'h9 || ins[7:4] == 4'hb)
      u_qpot_bus.x(8'hff, 1'b0, r, a);
    else if (ins[7:4] == 4'ha || ins[7:4] == 4'hc) begin
      u_qpot_bus.x(d, 1'b1, r, a);
      chk(8'(a), 8'h0);
    end
    if (ins[7:4] != 4'h2)
      u_qpot_bus.p();
  endtask
  task automatic t_addr;
    strap = ~SA;
    nack({TC, SA});
    strap = SA;
    nack({~TC, SA});
  endtask
  task automatic t_wiper;
    logic [5:0] v;
    for (int p = 0; p < 4; p++) begin
      v = 6'h05 + 6'(13 * p);
      op({6'h28, 2'(p)}, {2'(p), v});
      chk(pot(p), {2'b00, v});
      op({6'h24, 2'(p)}, 8'h00);
      chk(r, {2'b00, v});
    end
  endtask
  task automatic t_slot;
    op(8'hce, 8'h2d);
    chk(8'(busy), 8'h1);
    nack({TC, SA});
    op(8'hbe, 8'h00);
    chk(r, 8'h2d);
    op(8'hde, 8'h00);
    chk(pot(2), 8'h2d);
    op(8'ha2, 8'h07);
    op(8'he6, 8'h00);
    op(8'hb6, 8'h00);
    chk(r, 8'h07);
  endtask
  task automatic steps(input logic [7:0] w0, input logic d, input logic [7:0] e);
    op(8'ha3, w0);
    op(8'h23, 8'h00);
    repeat (3) u_qpot_bus.b(d, a);
    u_qpot_bus.p();
    chk(pot(3), e);
  endtask
  task automatic t_step;
    steps(8'h3e, 1'b1, 8'h3f);
    steps(8'h01, 1'b0, 8'h00);
    steps(8'h10, 1'b0, 8'h0d);
  endtask
  task automatic t_global;
    for (int p = 0; p < 4; p++)
      op({6'h28, 2'(p)}, 8'h30 + 8'(p));
    op(8'h84, 8'h00);
    for (int p = 0; p < 4; p++)
      op({6'h28, 2'(p)}, 8'h00);
    op(8'h14, 8'h00);
    for (int p = 0; p < 4; p++)
      chk(pot(p), 8'h30 + 8'(p));
  endtask
  initial begin
    repeat (16) @(negedge clk_in);
    reset_in = 1'b0;
    repeat (6) @(negedge clk_in);
    for (int p = 0; p < 4; p++)
      chk(pot(p), 8'h20);
    t_addr();
    t_wiper();
    t_slot();
    t_step();
    t_global();
    finish_test();
  end
endmodule
